// ==== rtl/opaddr_consts.svh ====
// Constants for the operand address generator.
`ifndef OPADDR_CONSTS_SVH
`define OPADDR_CONSTS_SVH
`define ADDR_W 20
`define WORD_W 16
`define EXT_W 4
`define LOW64K_TOP 20'h0_FFFF
`define SIZE_BW_AWORD 2'h1
`define ADDR_RESET 20'h0_0000
`endif

// ==== rtl/opaddr_pkg.sv ====
// Types for the operand address generator.
package opaddr_pkg;
  typedef enum logic [2:0] {
    MODE_INDEXED = 3'b001,
    MODE_SYMBOLIC = 3'b010,
    MODE_ABSOLUTE = 3'b100
  } addr_mode_type;
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b01,
    SIZE_WORD = 2'b10,
    SIZE_AWORD = 2'b11
  } op_size_type;
endpackage

// ==== rtl/operand_address_generator.sv ====
// Operand effective-address generator for indexed, symbolic and absolute modes.
`timescale 1ns/1ps
`include "opaddr_consts.svh"

module operand_address_generator
  import opaddr_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic valid_in,
  input wire addr_mode_type mode_in,
  input wire logic ext_prefix_in,
  input wire logic [`EXT_W-1:0] ext_index_hi_in,
  input wire logic ext_addr_len_in,
  input wire logic [1:0] size_bits_in,
  input wire logic [`WORD_W-1:0] index_word_in,
  input wire logic [`ADDR_W-1:0] index_word_addr_in,
  input wire logic [`ADDR_W-1:0] base_register_in,
  output logic valid_out,
  output logic [`ADDR_W-1:0] operand_addr_out,
  output op_size_type op_size_out,
  output logic [`ADDR_W-1:0] base_register_out
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Reset leaves in two steps so that a release close to a clock edge cannot
  // leave half of the output flops in reset and half running.
  logic rst_meta_n;
  logic rst_n;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // Index assembly and address sums
  // ----------------------------------------------------------------
  wire logic [`ADDR_W-1:0] ext_index = {ext_index_hi_in, index_word_in};
  wire logic [`ADDR_W-1:0] sext_index = {{`EXT_W{index_word_in[`WORD_W-1]}}, index_word_in};
  wire logic [`ADDR_W-1:0] index_sel = ext_prefix_in ? ext_index : sext_index;
  // The symbolic base is the location of the index word, not of the opcode.
  wire logic [`ADDR_W-1:0] base_sel = (mode_in == MODE_SYMBOLIC) ? index_word_addr_in : base_register_in;
  wire logic [`ADDR_W:0] raw_sum = {1'b0, base_sel} + {1'b0, index_sel};
  wire logic [`ADDR_W-1:0] wrap_sum = raw_sum[`ADDR_W-1:0];
  wire logic base_low = (base_sel <= `LOW64K_TOP);
  // Legacy forms running in the low 64 KB are truncated so old code never leaves it.
  wire logic [`ADDR_W-1:0] trunc_sum = {{`EXT_W{1'b0}}, wrap_sum[`WORD_W-1:0]};
  wire logic [`ADDR_W-1:0] legacy_rel = base_low ? trunc_sum : wrap_sum;
  wire logic [`ADDR_W-1:0] rel_addr = ext_prefix_in ? wrap_sum : legacy_rel;
  wire logic [`ADDR_W-1:0] abs_addr = ext_prefix_in ? ext_index : {{`EXT_W{1'b0}}, index_word_in};
  wire logic [`ADDR_W-1:0] next_addr = (mode_in == MODE_ABSOLUTE) ? abs_addr : rel_addr;

  // ----------------------------------------------------------------
  // Operand size decode
  // ----------------------------------------------------------------
  // A byte code under a 20-bit extension prefix names an address-word operand.
  // Every other code pattern keeps its plain meaning.
  op_size_type next_size;
  always_comb begin
    next_size = SIZE_WORD;
    if (size_bits_in == `SIZE_BW_AWORD) begin
      next_size = SIZE_BYTE;
    end
    if (ext_prefix_in && !ext_addr_len_in && size_bits_in == `SIZE_BW_AWORD) begin
      next_size = SIZE_AWORD;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Data outputs load only on a taken request and hold in between.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      valid_out <= 1'b0;
      operand_addr_out <= `ADDR_RESET;
      op_size_out <= SIZE_WORD;
      base_register_out <= `ADDR_RESET;
    end else begin
      valid_out <= valid_in;
      if (valid_in) begin
        operand_addr_out <= next_addr;
        op_size_out <= next_size;
        base_register_out <= base_register_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n);

  sequence ext_indexed_req;
    valid_in && ext_prefix_in && mode_in == MODE_INDEXED;
  endsequence

  sequence ext_symbolic_req;
    valid_in && ext_prefix_in && mode_in == MODE_SYMBOLIC;
  endsequence

  sequence ext_absolute_req;
    valid_in && ext_prefix_in && mode_in == MODE_ABSOLUTE;
  endsequence

  sequence legacy_abs_req;
    valid_in && !ext_prefix_in && mode_in == MODE_ABSOLUTE;
  endsequence

  sequence legacy_sym_low_req;
    valid_in && !ext_prefix_in && mode_in == MODE_SYMBOLIC && index_word_addr_in <= `LOW64K_TOP;
  endsequence

  sequence legacy_sym_high_req;
    valid_in && !ext_prefix_in && mode_in == MODE_SYMBOLIC && index_word_addr_in > `LOW64K_TOP;
  endsequence

  sequence legacy_idx_low_req;
    valid_in && !ext_prefix_in && mode_in == MODE_INDEXED && base_register_in <= `LOW64K_TOP;
  endsequence

  sequence legacy_idx_high_req;
    valid_in && !ext_prefix_in && mode_in == MODE_INDEXED && base_register_in > `LOW64K_TOP;
  endsequence

  // Size code requests, split by how the extension prefix reshapes the byte code.
  sequence byte_size_req;
    valid_in && !(ext_prefix_in && !ext_addr_len_in) && size_bits_in == `SIZE_BW_AWORD;
  endsequence

  sequence word_size_req;
    valid_in && size_bits_in != `SIZE_BW_AWORD;
  endsequence

  sequence idle_req;
    !valid_in;
  endsequence

  chk_ext_indexed_sum: assert property (ext_indexed_req |=>
    operand_addr_out == 20'(($past(base_register_in) + {$past(ext_index_hi_in), $past(index_word_in)})))
    else $error("extended indexed address wrong");
  chk_base_kept_same: assert property (valid_in |=> base_register_out == $past(base_register_in))
    else $error("base register value altered");
  chk_ext_abs_join: assert property (valid_in && ext_prefix_in && mode_in == MODE_ABSOLUTE |=>
    operand_addr_out == {$past(ext_index_hi_in), $past(index_word_in)})
    else $error("extended index assembly wrong");
  chk_aword_size_map: assert property (valid_in && ext_prefix_in && !ext_addr_len_in && size_bits_in == 2'h1 |=>
    op_size_out == SIZE_AWORD)
    else $error("address-word size not chosen");
  chk_sym_low_trunc: assert property (valid_in && !ext_prefix_in && mode_in == MODE_SYMBOLIC
    && index_word_addr_in <= 20'h0_FFFF |=> operand_addr_out[19:16] == 4'h0)
    else $error("low symbolic address not truncated");
  chk_sym_upper_sum: assert property (valid_in && !ext_prefix_in && mode_in == MODE_SYMBOLIC
    && index_word_addr_in > 20'h0_FFFF |=> operand_addr_out ==
    20'($past(index_word_addr_in) + {{4{$past(index_word_in[15])}}, $past(index_word_in)}))
    else $error("upper symbolic sum wrong");
  chk_ext_sym_sum: assert property (valid_in && ext_prefix_in && mode_in == MODE_SYMBOLIC |=>
    operand_addr_out == 20'($past(index_word_addr_in) + {$past(ext_index_hi_in), $past(index_word_in)}))
    else $error("extended symbolic sum wrong");
  chk_legacy_abs_low: assert property (valid_in && !ext_prefix_in && mode_in == MODE_ABSOLUTE |=>
    operand_addr_out == {4'h0, $past(index_word_in)})
    else $error("legacy absolute address wrong");
  chk_idx_low_trunc: assert property (valid_in && !ext_prefix_in && mode_in == MODE_INDEXED
    && base_register_in <= 20'h0_FFFF |=> operand_addr_out ==
    {4'h0, 16'($past(base_register_in[15:0]) + $past(index_word_in))})
    else $error("low indexed address wrong");
  chk_valid_follow: assert property (valid_in |=> valid_out)
    else $error("valid not echoed");

  // ----------------------------------------------------------------
  // Checks built on the request sequences
  // ----------------------------------------------------------------
  chk_ext_sym_offset: assert property (ext_symbolic_req |=>
    20'(operand_addr_out - $past(index_word_addr_in)) == {$past(ext_index_hi_in), $past(index_word_in)})
    else $error("extended symbolic offset wrong");
  chk_ext_abs_range: assert property (ext_absolute_req |=>
    operand_addr_out[19:16] == $past(ext_index_hi_in) && operand_addr_out[15:0] == $past(index_word_in))
    else $error("extended absolute address wrong");
  chk_abs_low_range: assert property (legacy_abs_req |=> operand_addr_out <= `LOW64K_TOP)
    else $error("legacy absolute address above low memory");
  chk_sym_low_sum: assert property (legacy_sym_low_req |=>
    operand_addr_out == {4'h0, 16'($past(index_word_addr_in[15:0]) + $past(index_word_in))})
    else $error("low symbolic sum wrong");
  chk_sym_high_offset: assert property (legacy_sym_high_req |=>
    20'(operand_addr_out - $past(index_word_addr_in)) == {{4{$past(index_word_in[15])}}, $past(index_word_in)})
    else $error("upper symbolic offset wrong");
  chk_idx_low_range: assert property (legacy_idx_low_req |=> operand_addr_out <= `LOW64K_TOP)
    else $error("low indexed address above low memory");
  chk_idx_high_sum: assert property (legacy_idx_high_req |=>
    operand_addr_out == 20'($past(base_register_in) + {{4{$past(index_word_in[15])}}, $past(index_word_in)}))
    else $error("upper indexed sum wrong");
  chk_size_byte_map: assert property (byte_size_req |=> op_size_out == SIZE_BYTE)
    else $error("byte size not chosen");
  chk_size_word_map: assert property (word_size_req |=> op_size_out == SIZE_WORD)
    else $error("word size not chosen");
  chk_output_hold: assert property (idle_req |=>
    $stable(operand_addr_out) && $stable(op_size_out) && $stable(base_register_out))
    else $error("outputs moved without a request");
  chk_valid_idle: assert property (idle_req |=> !valid_out)
    else $error("valid raised without a request");

endmodule

// ==== tb/mem_bus_model.sv ====
// Memory address bus sink that counts operand addresses.
`timescale 1ns/1ps
module mem_bus_model (
  input wire logic clock_in,
  input wire logic valid_in,
  input wire logic [19:0] addr_in,
  output int n_addr_out
);
  initial n_addr_out = 0;
  always @(posedge clock_in) if (valid_in === 1'b1 && !$isunknown(addr_in)) n_addr_out <= n_addr_out + 1;
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the operand address generator.
`timescale 1ns/1ps
`include "opaddr_consts.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("FAIL %0t %s", $time, "mismatch"); end end
module tb_top import opaddr_pkg::*; ;
  logic clock_in = 0, arst_n_in = 0, valid_in = 0, ext_prefix_in = 0, ext_addr_len_in = 0, valid_out;
  addr_mode_type mode_in = MODE_INDEXED;
  addr_mode_type modes [3] = '{MODE_INDEXED, MODE_SYMBOLIC, MODE_ABSOLUTE};
  logic [3:0] ext_index_hi_in = 0;
  logic [1:0] size_bits_in = 0;
  logic [15:0] index_word_in = 0;
  logic [19:0] index_word_addr_in = 0, base_register_in = 0, operand_addr_out, base_register_out, br;
  op_size_type op_size_out;
  logic [41:0] q [$];
  logic [41:0] ex;
  int errors = 0, n_checks = 0, n_sent = 0, n_addr, seed = 32'hefd6;
  always #10 clock_in = ~clock_in;
  operand_address_generator u_dut (.clock_in(clock_in), .arst_n_in(arst_n_in), .valid_in(valid_in),
    .mode_in(mode_in), .ext_prefix_in(ext_prefix_in), .ext_index_hi_in(ext_index_hi_in),
    .ext_addr_len_in(ext_addr_len_in), .size_bits_in(size_bits_in), .index_word_in(index_word_in),
    .index_word_addr_in(index_word_addr_in), .base_register_in(base_register_in), .valid_out(valid_out),
    .operand_addr_out(operand_addr_out), .op_size_out(op_size_out), .base_register_out(base_register_out));
  mem_bus_model u_bus (.clock_in(clock_in), .valid_in(valid_out), .addr_in(operand_addr_out), .n_addr_out(n_addr));
  task end_sim;
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task send(input addr_mode_type m, input logic e, al, input logic [1:0] sz, input logic [19:0] x, wa, b);
    logic [19:0] r;
    op_size_type sv;
    @(negedge clock_in);
    mode_in = m;
    {ext_prefix_in, ext_addr_len_in, size_bits_in, valid_in} = {e, al, sz, 1'b1};
    {ext_index_hi_in, index_word_in, index_word_addr_in, base_register_in} = {x, wa, b};
    r = e ? x : (m == MODE_ABSOLUTE ? {4'h0, x[15:0]} : {{4{x[15]}}, x[15:0]});
    r = r + (m == MODE_INDEXED ? b : (m == MODE_SYMBOLIC ? wa : 20'h0_0000));
    if (!e && m != MODE_ABSOLUTE && (m == MODE_INDEXED ? b : wa) <= `LOW64K_TOP) r[19:16] = 4'h0;
    sv = sz != 2'h1 ? SIZE_WORD : ((e && !al) ? SIZE_AWORD : SIZE_BYTE);
    q.push_back({r, sv, b});
    n_sent++;
  endtask
  always @(posedge clock_in) begin
    #1;
    if (valid_out === 1'b1) begin
      `CHK(q.size() > 0, 1'b1)
      ex = q.pop_front();
      `CHK(operand_addr_out, ex[41:22])
      `CHK(op_size_out, ex[21:20])
      `CHK(base_register_out, ex[19:0])
    end
  end
  initial begin
    #200000;
    errors++;
    end_sim;
  end
  initial begin
    repeat (5) @(negedge clock_in);
    arst_n_in = 1;
    repeat (3) @(posedge clock_in);
    send(MODE_INDEXED, 1, 0, 2'h1, 20'h1_2346, 20'h2_1036, 20'h2_3456);
    send(MODE_INDEXED, 0, 0, 2'h2, 20'h0_8346, 20'h0_0000, 20'h2_3456);
    send(MODE_INDEXED, 0, 0, 2'h1, 20'h0_F000, 20'h0_0000, 20'h0_1778);
    send(MODE_SYMBOLIC, 0, 1, 2'h1, 20'h0_F740, 20'h0_1038, 20'h7_7777);
    send(MODE_SYMBOLIC, 0, 0, 2'h2, 20'h0_4766, 20'h2_F036, 20'h0_0000);
    send(MODE_SYMBOLIC, 1, 1, 2'h1, 20'h1_4766, 20'h2_1036, 20'h0_0000);
    send(MODE_ABSOLUTE, 0, 0, 2'h3, 20'h0_8778, 20'hF_FFFF, 20'h1_0000);
    send(MODE_ABSOLUTE, 1, 0, 2'h0, 20'hF_0778, 20'h1_0000, 20'h0_0001);
    @(negedge clock_in) valid_in = 0;
    repeat (2) @(negedge clock_in);
    arst_n_in = 0;
    #1;
    `CHK(operand_addr_out, `ADDR_RESET)
    `CHK(base_register_out, `ADDR_RESET)
    `CHK(op_size_out, SIZE_WORD)
    `CHK(valid_out, 1'b0)
    @(negedge clock_in) arst_n_in = 1;
    repeat (3) @(posedge clock_in);
    repeat (300) begin
      br = $random(seed);
      if (br[0]) br[19:16] = 4'h0;
      send(modes[$unsigned($random(seed)) % 3], $random(seed), $random(seed), $random(seed), $random(seed),
        br[0] ? br : $random(seed), br);
      if ($random(seed) & 1) @(negedge clock_in) valid_in = 0;
    end
    @(negedge clock_in) valid_in = 0;
    repeat (3) @(negedge clock_in);
    `CHK(q.size(), 0)
    `CHK(n_addr, n_sent)
    end_sim;
  end
endmodule
